/* File: hw/fcs_defs.vh */
// register map, command codes and timing constants for the flash command sequencer
`ifndef FCS_DEFS_VH
`define FCS_DEFS_VH
`define FCS_A_CMD_AREA     24'h7E000
`define FCS_A_STATUS       24'h7E080
`define FCS_A_MODE_ENTRY   24'h7E084
`define FCS_A_SETUP_INIT   24'h7E08C
`define FCS_A_LOCK_STATUS  24'h7E090
`define FCS_A_CMD_HIST     24'h7E0A0
`define FCS_A_BC_RANGE     24'h7E0C8
`define FCS_A_TARGET       24'h7E0CC
`define FCS_A_BC_RESULT    24'h7FE0D4
`define FCS_A_FIRST_PROG   24'h7FE0D8
`define FCS_A_SUSP_POLICY  24'h7FE0E0
`define FCS_A_CLK_NOTIFY   24'h7FE0E4
`define FCS_A_IRQ_EN       24'h7E0E8
`define FCS_A_SIM_RESULT   24'h7E0EC
`define FCS_CMD_PROGRAM    8'hE8
`define FCS_CMD_ERASE      8'h20
`define FCS_CMD_SUSPEND    8'hB0
`define FCS_CMD_FINAL      8'hD0
`define FCS_CMD_CLEAR      8'h50
`define FCS_CMD_STOP       8'hB3
`define FCS_CMD_BLANK      8'h71
`define FCS_CMD_CONFIG     8'h40
`define FCS_CMD_LOCKPROG   8'h77
`define FCS_CNT_USER       8'h80
`define FCS_CNT_DATA       8'h02
`define FCS_CNT_CONFIG     8'h08
`define FCS_KEY_CLK        8'h1E
`define FCS_KEY_SETUP      8'h2D
`define FCS_KEY_MODE       8'hAA
`define FCS_MODE_READ      16'h0000
`define FCS_MODE_CODE      16'h0001
`define FCS_MODE_DATA      16'h0080
`define FCS_CLK_RESET      8'h3C
`define FCS_CYC_PER_MHZ    16'h0004
`define FCS_OFS_W          19
`endif

/* File: hw/fcs_sequencer.v */
// flash command sequencer with APB register slave and command-issuing area
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "fcs_defs.vh"
// Function
// R1 - blank result flag zero means erased
// R2 - capture 19-bit first programmed offset
// R3 - offset updates only when programmed found
// R4 - policy bit selects suspend or erase priority
// R5 - policy resets on setup init and reset
// R6 - clock field writes ignored while busy
// R7 - clock write needs 16-bit key 1Eh
// R8 - software loads MHz value before commands
// R9 - processing time scales with notified frequency
// R10 - mode 0000h read, no commands accepted; code still accepts B3h stop in read mode
// R11 - mode 0001h code flash program/erase
// R12 - mode 0080h data flash program/erase
// R13 - user program E8h 80h 128 words D0h
// R14 - data program E8h 02h two words D0h
// R15 - block erase is 20h then D0h
// R16 - B0h suspends, D0h resumes
// R17 - 50h clears errors and command lock
// R18 - B3h aborts and reinitialises status
// R19 - blank check 71h then D0h
// R20 - config set 40h 08h eight words D0h
// R21 - lock program 77h D0h, lock read 71h D0h
// R22 - ready drops on start, interrupt on rise
// R23 - unacceptable command enters command lock
// R24 - malformed sequence sets illegal flag, locks
module fcs_sequencer #(
	parameter BG_READ_EN = 1'b1
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [23:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	output reg         ready_irq,
	output reg         code_read_en,
	output reg         data_read_en,
	output reg  [15:0] prog_word,
	output reg         prog_word_vld
);
	localparam S_IDLE = 3'h0;
	localparam S_CNT  = 3'h1;
	localparam S_DATA = 3'h2;
	localparam S_FIN  = 3'h3;
	localparam S_FIN2 = 3'h4;
	localparam OP_NONE  = 3'h0;
	localparam OP_PROG  = 3'h1;
	localparam OP_ERASE = 3'h2;
	localparam OP_BLANK = 3'h3;
	localparam OP_CONF  = 3'h4;
	localparam OP_LOCKP = 3'h5;
	localparam OP_LOCKR = 3'h6;

	reg  [2:0]  st_q;
	reg  [2:0]  op_q;
	reg  [7:0]  words_q;
	reg         busy_q;
	reg         susp_q;
	reg  [15:0] tmr_q;
	reg         ilgl_q;
	reg         erase_error_flag_q;
	reg         program_error_flag_q;
	reg         lock_q;
	reg         policy_q;
	reg  [7:0]  clk_mhz_q;
	reg  [15:0] mode_q;
	reg         irq_en_q;
	reg         bc_flag_q;
	reg  [18:0] first_ofs_q;
	reg         lock_stat_q;
	reg  [15:0] hist_q;
	reg  [15:0] bc_range_q;
	reg  [18:0] target_q;
	reg  [19:0] sim_res_q;
	reg         ready_d1_q;

	wire wr_en = psel & penable & pwrite;
	wire rd_en = psel & penable & ~pwrite;
	wire w16   = pstrb[1] & pstrb[0];
	// a suspended operation hands the sequencer back, so ready reads 1 while parked
	wire ready = ~busy_q | susp_q;
	wire [7:0] wcmd = pwdata[7:0];
	wire cmd_wr  = wr_en & (paddr == `FCS_A_CMD_AREA);
	wire in_code = (mode_q == `FCS_MODE_CODE);
	wire in_data = (mode_q == `FCS_MODE_DATA);
	wire pe_mode = in_code | in_data;

	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// a processing duration: base cycles per notified MHz, never less than one
	function [15:0] dur;
		input [7:0] mhz;
		input [7:0] mult;
		reg   [15:0] p;
		begin
			p = mhz * mult;
			dur = (p == 16'h0000) ? 16'h0001 : p;
		end
	endfunction

	// command match: true when the data byte equals the given command code
	function is_cmd;
		input [7:0] c;
		input [7:0] v;
		begin
			is_cmd = (c == v);
		end
	endfunction

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q        <= S_IDLE;
			op_q        <= OP_NONE;
			words_q     <= 8'h00;
			busy_q      <= 1'b0;
			susp_q      <= 1'b0;
			tmr_q       <= 16'h0000;
			ilgl_q      <= 1'b0;
			erase_error_flag_q    <= 1'b0;
			program_error_flag_q    <= 1'b0;
			lock_q      <= 1'b0;
			policy_q    <= 1'b0;
			clk_mhz_q   <= `FCS_CLK_RESET;
			mode_q      <= `FCS_MODE_READ;
			irq_en_q    <= 1'b0;
			bc_flag_q   <= 1'b0;
			first_ofs_q <= 19'h00000;
			lock_stat_q <= 1'b0;
			hist_q      <= 16'h0000;
			bc_range_q  <= 16'h0000;
			target_q    <= 19'h00000;
			sim_res_q   <= 20'h00000;
			prog_word   <= 16'h0000;
			prog_word_vld <= 1'b0;
		end else begin
			prog_word_vld <= 1'b0;
			// command completion, timed from notified frequency
			if (busy_q && !susp_q) begin
				if (tmr_q == 16'h0001) begin
					busy_q <= 1'b0; // R22
					if (op_q == OP_BLANK) begin
						bc_flag_q <= sim_res_q[19]; // R1
						if (sim_res_q[19])
							first_ofs_q <= sim_res_q[18:0]; // R2 R3
					end
					if (op_q == OP_LOCKR)
						lock_stat_q <= sim_res_q[0]; // R21
					op_q <= OP_NONE;
				end else begin
					tmr_q <= tmr_q - 16'h0001; // R9
				end
			end
			if (wr_en) begin
				case (paddr)
				`FCS_A_SUSP_POLICY: policy_q <= pwdata[0]; // R4
				`FCS_A_CLK_NOTIFY: begin
					if (ready && w16 && pwdata[15:8] == `FCS_KEY_CLK)
						clk_mhz_q <= pwdata[7:0]; // R6 R7
				end
				`FCS_A_MODE_ENTRY: begin
					if (ready && w16 && pwdata[15:8] == `FCS_KEY_MODE) begin
						if (mode_q == `FCS_MODE_READ)
							mode_q <= {8'h00, pwdata[7], 6'h00, pwdata[0] & ~pwdata[7]};
						else
							mode_q <= `FCS_MODE_READ;
					end
				end
				`FCS_A_SETUP_INIT: begin
					if (ready && w16 && pwdata[15:8] == `FCS_KEY_SETUP && pwdata[0]) begin
						policy_q   <= 1'b0; // R5
						mode_q     <= `FCS_MODE_READ;
						bc_range_q <= 16'h0000;
						target_q   <= 19'h00000;
					end
				end
				`FCS_A_IRQ_EN:     irq_en_q   <= pwdata[0];
				`FCS_A_BC_RANGE:   bc_range_q <= pwdata[15:0];
				`FCS_A_TARGET:     target_q   <= pwdata[18:0];
				`FCS_A_SIM_RESULT: sim_res_q  <= pwdata[19:0];
				default: ;
				endcase
			end
			if (cmd_wr) begin
				if (is_cmd(wcmd, `FCS_CMD_STOP)) begin
					// forced stop wins in every state
					st_q <= S_IDLE; // R18
					op_q <= OP_NONE;
					busy_q <= 1'b0;
					susp_q <= 1'b0;
					ilgl_q <= 1'b0;
					erase_error_flag_q <= 1'b0;
					program_error_flag_q <= 1'b0;
					lock_q <= 1'b0;
					hist_q <= {wcmd, hist_q[15:8]};
				end else if (!pe_mode) begin
					ilgl_q <= 1'b1; // R10 R23
					lock_q <= 1'b1;
				end else if (lock_q) begin
					if (is_cmd(wcmd, `FCS_CMD_CLEAR) && ready) begin
						ilgl_q <= 1'b0; // R17
						erase_error_flag_q <= 1'b0;
						program_error_flag_q <= 1'b0;
						lock_q <= 1'b0;
						st_q <= S_IDLE;
					end
				end else begin
					case (st_q)
					S_IDLE: begin
						hist_q <= {wcmd, hist_q[15:8]};
						if (busy_q && !susp_q) begin
							if (is_cmd(wcmd, `FCS_CMD_SUSPEND) &&
								(op_q == OP_PROG || (op_q == OP_ERASE && !policy_q)))
								susp_q <= 1'b1; // R4 R16
							else if (!(is_cmd(wcmd, `FCS_CMD_SUSPEND))) begin
								ilgl_q <= 1'b1; // R23
								lock_q <= 1'b1;
							end
						end else if (susp_q && is_cmd(wcmd, `FCS_CMD_FINAL)) begin
							susp_q <= 1'b0; // R16
						end else if (is_cmd(wcmd, `FCS_CMD_CLEAR)) begin
							ilgl_q <= 1'b0; // R17
							erase_error_flag_q <= 1'b0;
							program_error_flag_q <= 1'b0;
						end else if (is_cmd(wcmd, `FCS_CMD_PROGRAM)) begin
							st_q <= S_CNT; // R13 R14
							op_q <= OP_PROG;
						end else if (is_cmd(wcmd, `FCS_CMD_CONFIG) && in_data && !susp_q) begin
							st_q <= S_CNT; // R20
							op_q <= OP_CONF;
						end else if (is_cmd(wcmd, `FCS_CMD_ERASE) && !susp_q) begin
							st_q <= S_FIN2; // R15
							op_q <= OP_ERASE;
						end else if (is_cmd(wcmd, `FCS_CMD_BLANK)) begin
							st_q <= S_FIN2; // R19 R21
							op_q <= in_data ? OP_BLANK : OP_LOCKR;
						end else if (is_cmd(wcmd, `FCS_CMD_LOCKPROG) && in_code && !susp_q) begin
							st_q <= S_FIN2; // R21
							op_q <= OP_LOCKP;
						end else begin
							ilgl_q <= 1'b1; // R23
							lock_q <= 1'b1;
						end
					end
					S_CNT: begin
						if ((op_q == OP_CONF && wcmd == `FCS_CNT_CONFIG) ||
							(op_q == OP_PROG && in_code && wcmd == `FCS_CNT_USER) ||
							(op_q == OP_PROG && in_data && wcmd == `FCS_CNT_DATA)) begin
							words_q <= wcmd;
							st_q <= S_DATA;
						end else begin
							ilgl_q <= 1'b1; // R24
							lock_q <= 1'b1;
							st_q <= S_IDLE;
							op_q <= OP_NONE;
						end
					end
					S_DATA: begin
						prog_word <= pwdata[15:0];
						prog_word_vld <= 1'b1;
						words_q <= words_q - 8'h01;
						if (words_q == 8'h01)
							st_q <= S_FIN;
					end
					default: begin
						if (is_cmd(wcmd, `FCS_CMD_FINAL)) begin
							st_q <= S_IDLE;
							busy_q <= 1'b1; // R22
							tmr_q <= dur(clk_mhz_q, (op_q == OP_PROG) ? 8'h08 :
								(op_q == OP_ERASE) ? 8'h20 : 8'h04); // R9
							if (op_q == OP_BLANK)
								sim_res_q[19] <= sim_res_q[19];
							hist_q <= {wcmd, (st_q == S_FIN2) ? hist_q[15:8] : hist_q[7:0]};
						end else begin
							ilgl_q <= 1'b1; // R24
							lock_q <= 1'b1;
							st_q <= S_IDLE;
							op_q <= OP_NONE;
						end
					end
					endcase
				end
			end
		end
	end

	// ready interrupt: one-cycle pulse on the rising edge of the ready flag
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_d1_q   <= 1'b1;
			ready_irq    <= 1'b0;
			code_read_en <= 1'b1;
			data_read_en <= 1'b1;
		end else begin
			ready_d1_q   <= ready;
			ready_irq    <= irq_en_q & ready & ~ready_d1_q; // R22
			code_read_en <= ~in_code | BG_READ_EN; // R10 R11 R12
			data_read_en <= ~pe_mode; // R11 R12
		end
	end

	always @* begin
		prdata = 32'h00000000;
		if (rd_en) begin
			case (paddr)
			`FCS_A_STATUS:      prdata = {24'h000000, ready, susp_q, 1'b0, ilgl_q,
				erase_error_flag_q, program_error_flag_q, lock_q, 1'b0};
			`FCS_A_MODE_ENTRY:  prdata = {16'h0000, mode_q};
			`FCS_A_LOCK_STATUS: prdata = {31'h0, lock_stat_q};
			`FCS_A_CMD_HIST:    prdata = {16'h0000, hist_q};
			`FCS_A_BC_RANGE:    prdata = {16'h0000, bc_range_q};
			`FCS_A_TARGET:      prdata = {13'h0000, target_q};
			`FCS_A_BC_RESULT:   prdata = {31'h0, bc_flag_q};
			`FCS_A_FIRST_PROG:  prdata = {13'h0000, first_ofs_q};
			`FCS_A_SUSP_POLICY: prdata = {31'h0, policy_q};
			`FCS_A_CLK_NOTIFY:  prdata = {24'h000000, clk_mhz_q}; // R7
			`FCS_A_IRQ_EN:      prdata = {31'h0, irq_en_q};
			`FCS_A_SIM_RESULT:  prdata = {12'h000, sim_res_q};
			default:            prdata = 32'h00000000;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: dv/fcs_apb_host.sv */
// processor model that issues APB transfers and command sequences
`timescale 1ns/100ps
`default_nettype none
`include "fcs_defs.vh"
module fcs_apb_host (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [23:0] paddr,
	output var  logic [31:0] pwdata,
	output var  logic [3:0]  pstrb
);
	logic [31:0] q;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 24'h0;
		pwdata = 32'h0;
		pstrb = 4'h0;
	end
	// request held until pready is sampled high at a rising edge
	task xfer(input bit w, input [23:0] a, input [31:0] d, input [3:0] s, output [31:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines must not keep showing the last value
		pwdata <= ~d;
		paddr <= ~a;
	endtask
	task key(input [23:0] a, input [7:0] k, input [7:0] v);
		xfer(1'b1, a, {16'h0, k, v}, 4'h3, q);
	endtask
	task cmd(input [15:0] d);
		xfer(1'b1, `FCS_A_CMD_AREA, {16'h0, d}, 4'h3, q);
	endtask
endmodule
`default_nettype wire

/* File: dv/fcs_sequencer_checker.sv */
// port assertions for the flash command sequencer
`timescale 1ns/100ps
`default_nettype none
`include "fcs_defs.vh"
module fcs_sequencer_checker #(
	parameter BG_READ_EN = 1'b1
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [23:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        ready_irq,
	input wire logic        code_read_en,
	input wire logic        data_read_en,
	input wire logic [15:0] prog_word,
	input wire logic        prog_word_vld
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd_acc = psel && penable && !pwrite;
	wire wr_acc = psel && penable && pwrite;
	a_zero_wait: assert property (psel && penable |-> pready && !pslverr)
		else $error("access not answered at once");
	a_rdata_idle: assert property (!rd_acc |-> prdata == 32'h0) else $error("read data leaks");
	a_irq_pulse: assert property (ready_irq |=> !ready_irq)
		else $error("ready interrupt longer than one cycle");
	a_word_source: assert property (prog_word_vld |-> $past(wr_acc && paddr == `FCS_A_CMD_AREA)
		&& prog_word == $past(pwdata[15:0])) else $error("data word not from bus");
	a_word_pulse: assert property (prog_word_vld |=> !prog_word_vld)
		else $error("word strobe too long");
	a_clk_key_zero: assert property (rd_acc && paddr == `FCS_A_CLK_NOTIFY |-> prdata[31:8] == 24'h0)
		else $error("clock key readable");
	a_bc_flag_only: assert property (rd_acc && paddr == `FCS_A_BC_RESULT |-> prdata[31:1] == 31'h0)
		else $error("blank result reserved bits set");
	a_offset_width: assert property (rd_acc && paddr == `FCS_A_FIRST_PROG |-> prdata[31:19] == 13'h0)
		else $error("offset wider than 19 bits");
	a_policy_bit: assert property (rd_acc && paddr == `FCS_A_SUSP_POLICY |-> prdata[31:1] == 31'h0)
		else $error("policy reserved bits set");
	a_data_lock_cause: assert property ($fell(data_read_en) |-> $past(wr_acc && paddr == `FCS_A_MODE_ENTRY, 2))
		else $error("data read blocked without mode write");
	a_code_readable: assert property (BG_READ_EN |-> code_read_en)
		else $error("code flash blocked");
	cover property (ready_irq);
	cover property (prog_word_vld);
	cover property ($fell(data_read_en));
endmodule
bind fcs_sequencer fcs_sequencer_checker #(.BG_READ_EN(BG_READ_EN)) u_chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .ready_irq,
	.code_read_en, .data_read_en, .prog_word, .prog_word_vld);
`default_nettype wire

/* File: dv/test_flash_command_sequencer.sv */
// self-checking testbench for the flash command sequencer
`timescale 1ns/100ps
`default_nettype none
`include "fcs_defs.vh"
module test_flash_command_sequencer;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	wire         psel, penable, pwrite, pready, pslverr, ready_irq;
	wire         code_read_en, data_read_en, prog_word_vld;
	wire  [23:0] paddr;
	wire  [31:0] pwdata, prdata;
	wire  [3:0]  pstrb;
	wire  [15:0] prog_word;
	logic [31:0] rv;
	int          fails = 0, tests_run = 0, nv = 0, ni = 0, n;
	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		nv <= nv + prog_word_vld;
		ni <= ni + ready_irq;
	end
	fcs_sequencer #(.BG_READ_EN(1'b1)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .pready, .prdata, .pslverr, .ready_irq, .code_read_en, .data_read_en,
		.prog_word, .prog_word_vld);
	fcs_apb_host m (.pclk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb);
	task chk(input [31:0] got, input [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task rd(input [23:0] a, input [31:0] exp);
		m.xfer(1'b0, a, 32'h0, 4'hF, rv);
		chk(rv, exp);
	endtask
	task st(input [31:0] exp);
		m.xfer(1'b0, `FCS_A_STATUS, 32'h0, 4'hF, rv);
		chk(rv & 32'h52, exp);
	endtask
	// bounded poll; n keeps the number of status reads
	task rdy;
		n = 0;
		do begin
			m.xfer(1'b0, `FCS_A_STATUS, 32'h0, 4'hF, rv);
			n++;
		end while (rv[7] !== 1'b1 && n < 300);
		chk({31'h0, rv[7]}, 32'h1);
	endtask
	task two(input [7:0] op);
		m.cmd({8'h0, op});
		m.cmd({8'h0, `FCS_CMD_FINAL});
	endtask
	task prog(input [7:0] op, input [7:0] cnt);
		m.cmd({8'h0, op});
		m.cmd({8'h0, cnt});
		for (int i = 0; i < cnt; i++) m.cmd(16'hA500 + 16'(i));
		m.cmd({8'h0, `FCS_CMD_FINAL});
	endtask
	task ports(input [1:0] exp);
		// read enables follow the mode register one edge later
		@(posedge pclk);
		@(negedge pclk);
		chk({30'h0, code_read_en, data_read_en}, {30'h0, exp});
	endtask
	task summarize;
		if (fails == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge pclk);
		fails++;
		summarize;
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(`FCS_A_SUSP_POLICY, 32'h0);
		wr_clk_checks();
		wr_mode(8'h80);
		ports(2'b10);
		m.xfer(1'b1, `FCS_A_IRQ_EN, 32'h1, 4'hF, rv);
		m.xfer(1'b1, `FCS_A_SIM_RESULT, 32'h80123, 4'hF, rv);
		two(`FCS_CMD_BLANK);
		rdy;
		rd(`FCS_A_BC_RESULT, 32'h1);
		rd(`FCS_A_FIRST_PROG, 32'h123);
		chk(ni, 1);
		m.xfer(1'b1, `FCS_A_SIM_RESULT, 32'h00456, 4'hF, rv);
		two(`FCS_CMD_BLANK);
		rdy;
		rd(`FCS_A_BC_RESULT, 32'h0);
		rd(`FCS_A_FIRST_PROG, 32'h123);
		prog(`FCS_CMD_PROGRAM, `FCS_CNT_DATA);
		rdy;
		chk(nv, 2);
		two(`FCS_CMD_ERASE);
		m.key(`FCS_A_CLK_NOTIFY, `FCS_KEY_CLK, 8'h05);
		rdy;
		rd(`FCS_A_CLK_NOTIFY, 32'h01);
		two(`FCS_CMD_ERASE);
		m.cmd({8'h0, `FCS_CMD_STOP});
		rdy;
		chk({31'h0, n < 8}, 32'h1);
		st(32'h0);
		two(`FCS_CMD_ERASE);
		m.cmd({8'h0, `FCS_CMD_SUSPEND});
		rdy;
		st(32'h40);
		m.cmd({8'h0, `FCS_CMD_FINAL});
		rdy;
		st(32'h0);
		m.xfer(1'b1, `FCS_A_SUSP_POLICY, 32'h1, 4'hF, rv);
		rd(`FCS_A_SUSP_POLICY, 32'h1);
		two(`FCS_CMD_ERASE);
		m.cmd({8'h0, `FCS_CMD_SUSPEND});
		rdy;
		st(32'h0);
		m.cmd({8'h0, `FCS_CMD_ERASE});
		m.cmd({8'h0, `FCS_CMD_BLANK});
		st(32'h12);
		m.cmd({8'h0, `FCS_CMD_CLEAR});
		st(32'h0);
		two(`FCS_CMD_LOCKPROG);
		st(32'h12);
		m.cmd({8'h0, `FCS_CMD_CLEAR});
		prog(`FCS_CMD_CONFIG, `FCS_CNT_CONFIG);
		rdy;
		st(32'h0);
		m.key(`FCS_A_SETUP_INIT, `FCS_KEY_SETUP, 8'h01);
		rd(`FCS_A_SUSP_POLICY, 32'h0);
		ports(2'b11);
		wr_mode(8'h01);
		ports(2'b10);
		prog(`FCS_CMD_PROGRAM, `FCS_CNT_USER);
		rdy;
		chk(nv, 138);
		m.xfer(1'b1, `FCS_A_SIM_RESULT, 32'h1, 4'hF, rv);
		two(`FCS_CMD_BLANK);
		rdy;
		rd(`FCS_A_LOCK_STATUS, 32'h1);
		wr_mode(8'h00);
		m.cmd({8'h0, `FCS_CMD_PROGRAM});
		st(32'h12);
		rd(24'h000100, 32'h0);
		m.xfer(1'b1, `FCS_A_SUSP_POLICY, 32'h1, 4'hF, rv);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(`FCS_A_SUSP_POLICY, 32'h0);
		summarize;
	end
	task wr_mode(input [7:0] v);
		m.key(`FCS_A_MODE_ENTRY, `FCS_KEY_MODE, v);
	endtask
	// byte-wide and wrong-key writes must both leave the reset value
	task wr_clk_checks;
		rd(`FCS_A_CLK_NOTIFY, {24'h0, `FCS_CLK_RESET});
		m.xfer(1'b1, `FCS_A_CLK_NOTIFY, 32'h1E01, 4'h1, rv);
		m.key(`FCS_A_CLK_NOTIFY, 8'h1F, 8'h01);
		rd(`FCS_A_CLK_NOTIFY, {24'h0, `FCS_CLK_RESET});
		m.key(`FCS_A_CLK_NOTIFY, `FCS_KEY_CLK, 8'h01);
		rd(`FCS_A_CLK_NOTIFY, 32'h01);
	endtask
endmodule
`default_nettype wire
